// ===== ltsf_filter_decode.sv
`timescale 1ns/1ps
// Turns the filter field into switch-level controls for the output filter.
module ltsf_filter_decode (
  // Field input.
  input  wire logic [2:0] i_filter_resistor_select,
  // Decoded controls.
  output logic            o_filter_pin_connect,
  output logic            o_filter_bypass
);
  // ==========================================================================
  // Decode.
  // Code 0 isolates the amplifier from the filter pin and capacitor.
  assign o_filter_pin_connect = (i_filter_resistor_select != ltsf_pkg::FILT_OPEN);
  // Code 1 shorts the filter resistor.
  assign o_filter_bypass = (i_filter_resistor_select == ltsf_pkg::FILT_BYPASS);
endmodule

// ===== ltsf_pkg.sv
package ltsf_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [15:0] SW_CFG_ADDR   = 16'h20e4;
  localparam logic [15:0] CTRL_ADDR     = 16'h20ec;
  localparam logic [31:0] SW_CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0003;
  // ==========================================================================
  // Field layout.
  localparam int          SW_COUNT      = 13;
  localparam int          FILT_LSB      = 13;
  localparam int          LOAD_LSB      = 10;
  localparam int          FIELD_W       = 3;
  localparam int          CTRL_LOW_W    = 10;
  localparam logic [2:0]  FILT_OPEN     = 3'h0;
  localparam logic [2:0]  FILT_BYPASS   = 3'h1;
  localparam logic [2:0]  FILT_BEST_DC  = 3'h7;
endpackage

// ===== ltsf_switch_bank.sv
`timescale 1ns/1ps
// Per-switch storage: one generate loop, one flop per switch line.
module ltsf_switch_bank #(
  parameter int N = 13
) (
  // Clock and reset.
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // Write side.
  input  wire logic         i_wr,
  input  wire logic [N-1:0] i_wdata,
  // Switch drive.
  output logic      [N-1:0] o_sw
);
  // ==========================================================================
  // Switch flops.
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_sw
      // Each bit resets open and follows software writes.
      always_ff @(posedge i_core_clk)
      begin
        if (!i_resetn)
          o_sw[g] <= 1'b0;
        else if (i_wr)
          o_sw[g] <= i_wdata[g];
      end
    end
  endgenerate
endmodule

// ===== ltsf_top.sv
`timescale 1ns/1ps
module ltsf_top #(
  parameter int SW_N = 13
) (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // Register port.
  input  wire logic [15:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Switch controls, bit n closes switch n.
  output logic [SW_N-1:0]  o_switch,
  // Filter and load controls.
  output logic      [2:0]  o_filter_resistor_select,
  output logic      [2:0]  o_load_resistor_select,
  output logic             o_filter_pin_connect,
  output logic             o_filter_bypass
);
  // ==========================================================================
  // Decode and storage.
  logic             sw_wr;
  logic             ctrl_wr;
  logic [2:0]       filt_reg;
  logic [2:0]       load_reg;
  logic [9:0]       ctrl_low_reg;
  logic [31:0]      rdata_next;

  // Address match for each register.
  // Only the two exact word addresses are decoded.
  // Any other address falls through, so a stray write leaves every field alone.
  // The strobes are single cycles, so each match lasts one edge only.
  assign sw_wr   = i_wr && (i_addr == ltsf_pkg::SW_CFG_ADDR);
  assign ctrl_wr = i_wr && (i_addr == ltsf_pkg::CTRL_ADDR);

  // Switch bits; only the implemented low bits are stored.
  // Bit n of the switch word drives switch n, so bits 12 to 10 close switches twelve to ten.
  // Upper bits of the word are not stored and read back as zero.
  // A write replaces every switch at once; there is no per-bit set or clear.
  ltsf_switch_bank #(
    .N (SW_N)
  ) u_bank (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_wr       (sw_wr),
    .i_wdata    (i_wdata[SW_N-1:0]),
    .o_sw       (o_switch)
  );

  // Filter field.
  // This code picks the output filter resistor and so the filter cutoff.
  // It resets to the isolating code so the filter pin stays free after reset.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      filt_reg <= ltsf_pkg::CTRL_RESET[15:13];
    else if (ctrl_wr)
      filt_reg <= i_wdata[15:13];
  end

  // Load field.
  // The load resistor code is stored as written and passed straight out.
  // Its analog meaning lives in the resistor array, not in this block.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      load_reg <= ltsf_pkg::CTRL_RESET[12:10];
    else if (ctrl_wr)
      load_reg <= i_wdata[12:10];
  end

  // Low control bits hold the nonzero reset pattern.
  // These bits are kept as plain storage so the reset word reads back intact.
  // Software that rewrites the register must preserve them if it cares.
  // They have no decoded output of their own in this block.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      ctrl_low_reg <= ltsf_pkg::CTRL_RESET[9:0];
    else if (ctrl_wr)
      ctrl_low_reg <= i_wdata[9:0];
  end

  // Field outputs come straight from the flops, so they never glitch.
  // They change only on the edge that takes a control write or a reset.
  assign o_filter_resistor_select = filt_reg;
  assign o_load_resistor_select   = load_reg;

  // The decoder turns the filter code into the two switch-level controls.
  // It is pure logic on a register, so its outputs settle within the cycle.
  // Code 0 opens the path and code 1 shorts the resistor.
  ltsf_filter_decode u_dec (
    .i_filter_resistor_select (filt_reg),
    .o_filter_pin_connect     (o_filter_pin_connect),
    .o_filter_bypass          (o_filter_bypass)
  );

  // ==========================================================================
  // Read path, data one cycle after the strobe; unmapped reads return zero.
  // The word is built from the stored state that stands at the strobe edge.
  // Outside that one cycle the read data sit at zero, so stale data never linger.
  // Reserved positions are forced to zero by the default assignment.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (i_addr == ltsf_pkg::SW_CFG_ADDR)
      rdata_next[SW_N-1:0] = o_switch;
    else if (i_addr == ltsf_pkg::CTRL_ADDR)
      rdata_next[15:0] = {filt_reg, load_reg, ctrl_low_reg};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
      o_rdata <= rdata_next;
    else
      o_rdata <= 32'h0000_0000;
  end

  // ==========================================================================
  // Checks.
  filt_reset_a: assert property (@(posedge i_core_clk)
    $rose(i_resetn) |-> filt_reg == 3'h0 && load_reg == 3'h0)
    else $error("filter or load field not zero after reset");
  ctrl_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr |=> filt_reg == $past(i_wdata[15:13]) && load_reg == $past(i_wdata[12:10]))
    else $error("control write not stored");
  sw_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sw_wr |=> o_switch == $past(i_wdata[SW_N-1:0]))
    else $error("switch write not stored");
  sw_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !sw_wr |=> $stable(o_switch))
    else $error("switch changed without write");
  ctrl_rst_a: assert property (@(posedge i_core_clk)
    $rose(i_resetn) |-> ctrl_low_reg == 10'h003)
    else $error("control reset value wrong");
  rsvd_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd |=> o_rdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");
  filt_open_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    filt_reg == 3'h0 |-> !o_filter_pin_connect && !o_filter_bypass)
    else $error("filter not isolated at code 0");
  filt_bypass_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr && i_wdata[15:13] == 3'h1 |=> o_filter_bypass && o_filter_pin_connect)
    else $error("bypass not asserted");
  sw_rst_a: assert property (@(posedge i_core_clk)
    $rose(i_resetn) |-> o_switch == '0)
    else $error("switch reset not zero");

  // ==========================================================================
  // Read path checks.
  // The read data must stay at zero outside the cycle after a read strobe.
  // Each read is compared with the state that stood at the strobe edge.
  // Reserved and unmapped positions are held to zero as well.
  // A host that samples late must therefore see zero, never old data.

  rd_idle_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero while idle");

  rd_unmap_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd && i_addr != ltsf_pkg::SW_CFG_ADDR && i_addr != ltsf_pkg::CTRL_ADDR
      |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  rd_sw_data_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd && i_addr == ltsf_pkg::SW_CFG_ADDR |=> o_rdata[SW_N-1:0] == $past(o_switch))
    else $error("switch readback wrong");

  rd_sw_rsvd_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd && i_addr == ltsf_pkg::SW_CFG_ADDR |=> o_rdata[31:SW_N] == '0)
    else $error("switch reserved bits read nonzero");

  rd_ctrl_data_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd && i_addr == ltsf_pkg::CTRL_ADDR
      |=> o_rdata[15:0] == {$past(filt_reg), $past(load_reg), $past(ctrl_low_reg)})
    else $error("control readback wrong");

  rdata_reset_a: assert property (@(posedge i_core_clk)
    !i_resetn |=> o_rdata == 32'h0000_0000)
    else $error("read data not cleared by reset");

  // ==========================================================================
  // Switch checks.
  // Every switch line follows its own bit on a write to the switch word.
  // Between writes the lines must not move, since each one is an analog switch.
  // A write to any other address must leave the switches untouched.
  // Reset opens every switch on the edge after it is seen.

  sw_twelve_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sw_wr |=> o_switch[12] == $past(i_wdata[12]))
    else $error("switch twelve not written");

  sw_eleven_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sw_wr |=> o_switch[11] == $past(i_wdata[11]))
    else $error("switch eleven not written");

  sw_ten_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sw_wr |=> o_switch[10] == $past(i_wdata[10]))
    else $error("switch ten not written");

  sw_low_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sw_wr |=> o_switch[9:0] == $past(i_wdata[9:0]))
    else $error("low switches not written");

  sw_in_reset_a: assert property (@(posedge i_core_clk)
    !i_resetn |=> o_switch == '0)
    else $error("switches not opened by reset");

  sw_other_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_wr && i_addr != ltsf_pkg::SW_CFG_ADDR |=> $stable(o_switch))
    else $error("switches moved on foreign write");

  twelve_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !sw_wr |=> $stable(o_switch[12]))
    else $error("switch twelve moved without write");

  eleven_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !sw_wr |=> $stable(o_switch[11]))
    else $error("switch eleven moved without write");

  ten_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !sw_wr |=> $stable(o_switch[10]))
    else $error("switch ten moved without write");

  // ==========================================================================
  // Control field checks.
  // The filter, load and low fields take the written word on a control write.
  // They hold otherwise, and a write elsewhere must not disturb them.
  // Reset loads the documented nonzero word into the control register.
  // The field outputs are checked as well as the internal flops.

  filt_out_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr |=> o_filter_resistor_select == $past(i_wdata[15:13]))
    else $error("filter output not written");

  load_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr |=> o_load_resistor_select == $past(i_wdata[12:10]))
    else $error("load output not written");

  ctrl_low_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr |=> ctrl_low_reg == $past(i_wdata[9:0]))
    else $error("low control bits not written");

  filt_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !ctrl_wr |=> $stable(filt_reg))
    else $error("filter field moved without write");

  load_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !ctrl_wr |=> $stable(load_reg))
    else $error("load field moved without write");

  ctrl_low_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !ctrl_wr |=> $stable(ctrl_low_reg))
    else $error("low control bits moved without write");

  ctrl_in_reset_a: assert property (@(posedge i_core_clk)
    !i_resetn |=> filt_reg == 3'h0 && load_reg == 3'h0 && ctrl_low_reg == 10'h003)
    else $error("control word not reset");

  ctrl_other_addr_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_wr && i_addr != ltsf_pkg::CTRL_ADDR |=> $stable({filt_reg, load_reg, ctrl_low_reg}))
    else $error("control moved on foreign write");

  // ==========================================================================
  // Filter decode checks.
  // Any code but 0 must connect the amplifier output to the filter pin.
  // Only code 1 may short the filter resistor.
  // These guard the analog path against a wrong decode.
  // They are checked both on the stored code and on a fresh write.

  filt_connect_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    filt_reg != 3'h0 |-> o_filter_pin_connect)
    else $error("filter pin not connected");

  open_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr && i_wdata[15:13] == 3'h0 |=> !o_filter_pin_connect)
    else $error("filter pin not opened by write");

  bypass_only_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_filter_bypass |-> filt_reg == 3'h1)
    else $error("bypass on for wrong code");

  bypass_off_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ctrl_wr && i_wdata[15:13] != 3'h1 |=> !o_filter_bypass)
    else $error("bypass left on after write");
endmodule

// ===== ltsf_top_bench.sv
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
// ==========================================================================
// Register bank bench.
module ltsf_top_bench;
  logic        i_core_clk = 1'b0;
  logic        i_resetn   = 1'b0;
  logic [15:0] i_addr     = 16'h0000;
  logic [31:0] i_wdata    = 32'h0000_0000;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic [31:0] o_rdata;
  logic [12:0] o_switch;
  logic [2:0]  o_filt;
  logic [2:0]  o_load;
  logic        o_conn;
  logic        o_byp;
  logic [31:0] sw_m;
  logic [31:0] ct_m;
  logic [31:0] d;
  integer      seed = 61251;
  integer      fail_count = 0;
  integer      samples_checked = 0;
  integer      cyc = 0;
  ltsf_top dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_switch(o_switch),
    .o_filter_resistor_select(o_filt), .o_load_resistor_select(o_load),
    .o_filter_pin_connect(o_conn), .o_filter_bypass(o_byp));
  // Free-running core clock, 8 ns period.
  always #4 i_core_clk = ~i_core_clk;
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // One-cycle write strobe.
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(negedge i_core_clk);
  endtask
  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(negedge i_core_clk);
    q = o_rdata;
  endtask
  // Compares readback and every output with the model.
  task automatic chk_all;
    logic [31:0] q;
    rd(ltsf_pkg::SW_CFG_ADDR, q);
    `CHK(q, sw_m)
    rd(ltsf_pkg::CTRL_ADDR, q);
    `CHK(q, ct_m)
    `CHK(o_switch, sw_m[12:0])
    `CHK(o_filt, ct_m[15:13])
    `CHK(o_load, ct_m[12:10])
    `CHK(o_conn, ct_m[15:13] != 3'h0)
    `CHK(o_byp, ct_m[15:13] == 3'h1)
    @(negedge i_core_clk);
    `CHK(o_rdata, 32'h0000_0000)
  endtask
  // Main sequence.
  initial
  begin
    logic [31:0] q;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    sw_m = 32'h0000_0000;
    ct_m = 32'h0000_0003;
    chk_all();
    $display("test reset done");
    for (int i = 0; i < 13; i++)
    begin
      sw_m = 32'h0000_0001 << i;
      wr(ltsf_pkg::SW_CFG_ADDR, sw_m);
      chk_all();
    end
    for (int i = 0; i < 12; i++)
    begin
      d = $random(seed);
      wr(ltsf_pkg::SW_CFG_ADDR, d);
      sw_m = d & 32'h0000_1fff;
      chk_all();
    end
    $display("test switches done");
    for (int c = 0; c < 8; c++)
    begin
      d = $random(seed);
      d[15:13] = c[2:0];
      wr(ltsf_pkg::CTRL_ADDR, d);
      ct_m = d & 32'h0000_ffff;
      chk_all();
    end
    $display("test filter codes done");
    wr(16'h20e8, $random(seed));
    rd(16'h20e8, q);
    `CHK(q, 32'h0000_0000)
    chk_all();
    $display("test unmapped done");
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    sw_m = 32'h0000_0000;
    ct_m = 32'h0000_0003;
    chk_all();
    $display("test mid reset done");
    wrap_up();
  end
endmodule
